// ===== rtl/rftmr_pkg.sv
// Constants for the reader timer-one block: register map, field layout, tick timing.
// Assumes a 20 MHz system clock and an APB slave with 32-bit data.
package rftmr_pkg;
	// ----------------------------------------
	// Register indices (byte address = 4 * index)
	// ----------------------------------------
	localparam logic [7:0] IDX_T1_CONTROL = 8'h14;
	localparam logic [7:0] IDX_T1_RELOAD_HIGH = 8'h15;
	localparam logic [7:0] IDX_T1_RELOAD_LOW = 8'h16;
	localparam logic [7:0] IDX_T1_COUNT_HIGH = 8'h17;
	localparam logic [7:0] IDX_T1_COUNT_LOW = 8'h18;
	localparam logic [7:0] IDX_T2_CONTROL = 8'h19;
	localparam logic [7:0] IDX_RUN_CONTROL = 8'h20;
	localparam logic [7:0] IDX_IRQ_STATUS = 8'h21;
	localparam logic [7:0] IDX_IRQ_MASK = 8'h22;
	localparam logic [9:0] ADDR_MULT = 10'h004;

	// ----------------------------------------
	// Control register fields
	// ----------------------------------------
	localparam int BIT_STOP_RX = 7;
	localparam int BIT_START_HI = 5;
	localparam int BIT_START_LO = 4;
	localparam int BIT_AUTO_RELOAD = 3;
	localparam int BIT_TICK_HI = 1;
	localparam int BIT_TICK_LO = 0;
	localparam logic [7:0] CONTROL_WRITE_MASK = 8'hBB;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] BYTE_RESET = 8'h00;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_ONE = 16'h0001;

	// Running control: bit 0 indicator, bit 1 write enable
	localparam int BIT_RUNNING = 0;
	localparam int BIT_RUN_WE = 1;
	// Interrupt status/mask: bit 0 underflow
	localparam int BIT_IRQ_UNDERFLOW = 0;

	typedef enum logic [1:0] {START_NONE, START_TX_END, START_LFO_NOUF, START_LFO_UF}
		rftmr_start_t;
	typedef enum logic [1:0] {TICK_FAST, TICK_SLOW, TICK_CASCADE_A, TICK_CASCADE_B}
		rftmr_tick_t;

	// ----------------------------------------
	// Tick timing
	// ----------------------------------------
	localparam int CLK_HZ = 20_000_000;
	localparam int SLOW_TICK_HZ = 211_875;
	// Longest period rounds down; at least one cycle
	localparam int SLOW_DIV_CYCLES = (CLK_HZ / SLOW_TICK_HZ) < 1 ? 1 : (CLK_HZ / SLOW_TICK_HZ);
	localparam int SLOW_DIV_W = 8;
	localparam int RX_STOP_BITS = 4;
endpackage : rftmr_pkg

// ===== rtl/rftmr_tick_div.sv
// Slow tick generator: one-cycle pulse every DIV cycles.
// Assumes a single system clock and synchronous active-low reset.
`timescale 1ns/1ps
`default_nettype none
module rftmr_tick_div #(
	parameter int DIV = rftmr_pkg::SLOW_DIV_CYCLES,
	parameter int W = rftmr_pkg::SLOW_DIV_W
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Tick
	output logic tick
);
	logic [W-1:0] cnt_reg;
	localparam logic [W-1:0] LAST = W'(DIV - 1);
	localparam logic [W-1:0] ZERO = '0;
	localparam logic [W-1:0] ONE = W'(1);

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cnt_reg <= ZERO;
		end else if (cnt_reg == LAST) begin
			cnt_reg <= ZERO;
		end else begin
			cnt_reg <= cnt_reg + ONE;
		end
	end

	assign tick = (cnt_reg == LAST);
endmodule : rftmr_tick_div
`default_nettype wire

// ===== rtl/rftmr_timer.sv
// Timer one of a contactless reader front end with APB register access.
// Assumes single 20 MHz clock; event inputs are synchronous one-cycle pulses or levels.
// The 13.56 MHz tick is supplied as an enable pulse from the analog clock domain,
// already resynchronised to CLK.
//
// Implementation choice: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// Behaviour
// - Control bits: stop7, start5:4, reload3, tick1:0
// - Stop after first four received bits
// - Stop flag ignored in trimming modes
// - Mode 00 manual, 01 start at TX end
// - Modes 10/11 trim oscillator, rising edges
// - Auto-reload reloads on the tick at one, in place of the step to zero, keeps counting; mode 10 holds at one instead
// - Without reload, halt at zero; mode 10 holds at one and keeps running
// - Underflow sets interrupt flag
// - Tick 00 fast clock, 01 slow clock
// - Tick 10/11 cascade from sibling underflows
// - Start loads sixteen-bit reload word
// - High reload write spares running count
// - Low reload write spares running count
// - Count readable as two live bytes
// - Timer-two control uses same layout
// - Running bit written only with enable
module rftmr_timer #(
	parameter int COUNT_W = 16
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// APB slave
	input wire logic [31:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Radio events
	input wire logic TX_DONE,
	input wire logic RX_BIT_VALID,
	input wire logic RX_ACTIVE,
	input wire logic LFO_IN,
	input wire logic FAST_TICK,
	// Sibling timer underflows
	input wire logic TIMER0_UNDERFLOW,
	input wire logic TIMER2_UNDERFLOW,
	// Outputs
	output logic UNDERFLOW,
	output logic RUNNING,
	output logic [7:0] TIMER_TWO_CONTROL,
	output logic IRQ
);
	// ----------------------------------------
	// Register file
	// ----------------------------------------
	logic [7:0] ctrl_reg;
	logic [7:0] ctrl2_reg;
	logic [7:0] reload_hi_reg;
	logic [7:0] reload_lo_reg;
	logic [COUNT_W-1:0] count_reg;
	logic running_reg;
	logic irq_stat_reg;
	logic irq_mask_reg;
	logic [31:0] prdata_reg;
	logic underflow_reg;

	logic wr_en;
	logic rd_en;
	logic [7:0] reg_idx;
	logic addr_ok;
	logic slow_tick;
	logic tick;
	logic start_ev;
	logic stop_ev;
	logic uf_ev;
	logic count_at_one;
	logic lfo_d_reg;
	logic lfo_rise;
	logic [2:0] rx_cnt_reg;
	logic rx_stop;
	logic sw_run_we;
	logic sw_run_val;
	rftmr_pkg::rftmr_start_t start_mode;
	rftmr_pkg::rftmr_tick_t tick_src;

	// Byte address to register index
	function automatic logic [7:0] addr_to_idx(input logic [31:0] a);
		addr_to_idx = a[9:2];
	endfunction : addr_to_idx

	// reload word from its two bytes
	function automatic logic [COUNT_W-1:0] reload_word(input logic [7:0] hi,
		input logic [7:0] lo);
		reload_word = COUNT_W'({hi, lo});
	endfunction : reload_word

	function automatic logic is_mapped(input logic [31:0] a);
		logic [7:0] i;
		i = a[9:2];
		is_mapped = (a[31:10] == 22'h00_0000) && (a[1:0] == 2'b00) &&
			((i >= rftmr_pkg::IDX_T1_CONTROL && i <= rftmr_pkg::IDX_T2_CONTROL) ||
			(i >= rftmr_pkg::IDX_RUN_CONTROL && i <= rftmr_pkg::IDX_IRQ_MASK));
	endfunction : is_mapped

	assign reg_idx = addr_to_idx(PADDR);
	assign addr_ok = is_mapped(PADDR);
	// Zero wait state slave
	assign PREADY = 1'b1;
	assign PSLVERR = PSEL && PENABLE && !addr_ok;
	assign wr_en = PSEL && PENABLE && PWRITE && addr_ok;
	assign rd_en = PSEL && PENABLE && !PWRITE && addr_ok;
	assign PRDATA = prdata_reg;

	assign start_mode = rftmr_pkg::rftmr_start_t'(
		ctrl_reg[rftmr_pkg::BIT_START_HI:rftmr_pkg::BIT_START_LO]);
	assign tick_src = rftmr_pkg::rftmr_tick_t'(
		ctrl_reg[rftmr_pkg::BIT_TICK_HI:rftmr_pkg::BIT_TICK_LO]);

	// control registers, reserved bits held zero
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			ctrl_reg <= rftmr_pkg::CONTROL_RESET;
			ctrl2_reg <= rftmr_pkg::CONTROL_RESET;
		end else if (wr_en) begin
			if (reg_idx == rftmr_pkg::IDX_T1_CONTROL) begin
				ctrl_reg <= PWDATA[7:0] & rftmr_pkg::CONTROL_WRITE_MASK;
			end
			if (reg_idx == rftmr_pkg::IDX_T2_CONTROL) begin
				ctrl2_reg <= PWDATA[7:0] & rftmr_pkg::CONTROL_WRITE_MASK;
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			reload_hi_reg <= rftmr_pkg::BYTE_RESET;
			reload_lo_reg <= rftmr_pkg::BYTE_RESET;
		end else if (wr_en) begin
			if (reg_idx == rftmr_pkg::IDX_T1_RELOAD_HIGH) begin
				reload_hi_reg <= PWDATA[7:0];
			end
			if (reg_idx == rftmr_pkg::IDX_T1_RELOAD_LOW) begin
				reload_lo_reg <= PWDATA[7:0];
			end
		end
	end

	// ----------------------------------------
	// Tick selection
	// ----------------------------------------
	rftmr_tick_div #(
		.DIV(rftmr_pkg::SLOW_DIV_CYCLES),
		.W(rftmr_pkg::SLOW_DIV_W)
	) u_slow_div (
		.clk(CLK),
		.rst_n(RST_N),
		.tick(slow_tick)
	);

	always_comb begin
		unique case (tick_src)
			rftmr_pkg::TICK_FAST: tick = FAST_TICK;
			rftmr_pkg::TICK_SLOW: tick = slow_tick;
			rftmr_pkg::TICK_CASCADE_A: tick = TIMER0_UNDERFLOW;
			rftmr_pkg::TICK_CASCADE_B: tick = TIMER2_UNDERFLOW;
		endcase
	end

	// ----------------------------------------
	// Start and stop events
	// ----------------------------------------
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			lfo_d_reg <= 1'b0;
		end else begin
			lfo_d_reg <= LFO_IN;
		end
	end
	assign lfo_rise = LFO_IN && !lfo_d_reg;

	// count received bits of the frame, saturating at four
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			rx_cnt_reg <= 3'h0;
		end else if (!RX_ACTIVE) begin
			rx_cnt_reg <= 3'h0;
		end else if (RX_BIT_VALID && rx_cnt_reg != 3'(rftmr_pkg::RX_STOP_BITS)) begin
			rx_cnt_reg <= rx_cnt_reg + 3'h1;
		end
	end
	assign rx_stop = RX_ACTIVE && RX_BIT_VALID &&
		(rx_cnt_reg == 3'(rftmr_pkg::RX_STOP_BITS - 1));

	always_comb begin
		start_ev = 1'b0;
		stop_ev = 1'b0;
		unique case (start_mode)
			rftmr_pkg::START_NONE: start_ev = 1'b0;
			rftmr_pkg::START_TX_END: start_ev = TX_DONE;
			// trimming: rising edge starts when idle, stops when running
			rftmr_pkg::START_LFO_NOUF, rftmr_pkg::START_LFO_UF: begin
				start_ev = lfo_rise && !running_reg;
				stop_ev = lfo_rise && running_reg;
			end
		endcase
		if (ctrl_reg[rftmr_pkg::BIT_STOP_RX] && !start_mode[1] && rx_stop) begin
			stop_ev = 1'b1;
		end
	end

	// running write enable travels in the same access
	assign sw_run_we = wr_en && (reg_idx == rftmr_pkg::IDX_RUN_CONTROL) &&
		PWDATA[rftmr_pkg::BIT_RUN_WE];
	assign sw_run_val = PWDATA[rftmr_pkg::BIT_RUNNING];

	// Last step before zero, shared by underflow and count engine
	assign count_at_one = (count_reg == COUNT_W'(rftmr_pkg::COUNT_ONE));

	// Underflow: tick at count one (no-underflow trim mode holds instead)
	assign uf_ev = running_reg && tick && count_at_one &&
		(start_mode != rftmr_pkg::START_LFO_NOUF);

	// ----------------------------------------
	// Counter
	// ----------------------------------------
	// count engine
	// Software start while running keeps the count; stop first to restart
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			count_reg <= COUNT_W'(rftmr_pkg::COUNT_RESET);
		end else if (start_ev || (sw_run_we && sw_run_val && !running_reg)) begin
			count_reg <= reload_word(reload_hi_reg, reload_lo_reg);
		end else if (running_reg && !stop_ev && tick) begin
			if (count_at_one) begin
				if (start_mode == rftmr_pkg::START_LFO_NOUF) begin
					count_reg <= count_reg;
				end else if (ctrl_reg[rftmr_pkg::BIT_AUTO_RELOAD]) begin
					count_reg <= reload_word(reload_hi_reg, reload_lo_reg);
				end else begin
					count_reg <= count_reg - COUNT_W'(rftmr_pkg::COUNT_ONE);
				end
			end else if (count_reg != COUNT_W'(rftmr_pkg::COUNT_RESET)) begin
				count_reg <= count_reg - COUNT_W'(rftmr_pkg::COUNT_ONE);
			end
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			running_reg <= 1'b0;
		end else if (sw_run_we) begin
			running_reg <= sw_run_val;
		end else if (start_ev) begin
			running_reg <= 1'b1;
		end else if (stop_ev) begin
			running_reg <= 1'b0;
		end else if (uf_ev && !ctrl_reg[rftmr_pkg::BIT_AUTO_RELOAD]) begin
			running_reg <= 1'b0;
		end else if (running_reg && count_reg == COUNT_W'(rftmr_pkg::COUNT_RESET)) begin
			running_reg <= 1'b0;
		end
	end

	// sticky underflow flag, set beats clear
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_stat_reg <= 1'b0;
		end else if (uf_ev && !stop_ev) begin
			irq_stat_reg <= 1'b1;
		end else if (wr_en && reg_idx == rftmr_pkg::IDX_IRQ_STATUS &&
			PWDATA[rftmr_pkg::BIT_IRQ_UNDERFLOW]) begin
			irq_stat_reg <= 1'b0;
		end
	end

	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			irq_mask_reg <= 1'b0;
		end else if (wr_en && reg_idx == rftmr_pkg::IDX_IRQ_MASK) begin
			irq_mask_reg <= PWDATA[rftmr_pkg::BIT_IRQ_UNDERFLOW];
		end
	end

	// Underflow pulse for cascading siblings
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			underflow_reg <= 1'b0;
		end else begin
			underflow_reg <= uf_ev && !stop_ev;
		end
	end

	// ----------------------------------------
	// Read data
	// ----------------------------------------
	// live count bytes; reads during reception may tear
	always_ff @(posedge CLK) begin
		if (!RST_N) begin
			prdata_reg <= 32'h0000_0000;
		end else if (PSEL && !PENABLE && !PWRITE) begin
			prdata_reg <= 32'h0000_0000;
			unique case (addr_to_idx(PADDR))
				rftmr_pkg::IDX_T1_CONTROL: prdata_reg[7:0] <= ctrl_reg;
				rftmr_pkg::IDX_T1_RELOAD_HIGH: prdata_reg[7:0] <= reload_hi_reg;
				rftmr_pkg::IDX_T1_RELOAD_LOW: prdata_reg[7:0] <= reload_lo_reg;
				rftmr_pkg::IDX_T1_COUNT_HIGH: prdata_reg[7:0] <= count_reg[15:8];
				rftmr_pkg::IDX_T1_COUNT_LOW: prdata_reg[7:0] <= count_reg[7:0];
				rftmr_pkg::IDX_T2_CONTROL: prdata_reg[7:0] <= ctrl2_reg;
				rftmr_pkg::IDX_RUN_CONTROL: prdata_reg[rftmr_pkg::BIT_RUNNING] <= running_reg;
				rftmr_pkg::IDX_IRQ_STATUS: prdata_reg[rftmr_pkg::BIT_IRQ_UNDERFLOW] <= irq_stat_reg;
				rftmr_pkg::IDX_IRQ_MASK: prdata_reg[rftmr_pkg::BIT_IRQ_UNDERFLOW] <= irq_mask_reg;
				default: prdata_reg <= 32'h0000_0000;
			endcase
			// Refused addresses read zero, never an aliased register
			if (!addr_ok) begin
				prdata_reg <= 32'h0000_0000;
			end
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign UNDERFLOW = underflow_reg;
	assign RUNNING = running_reg;
	assign TIMER_TWO_CONTROL = ctrl2_reg;
	assign IRQ = irq_stat_reg && irq_mask_reg;

	logic unused_rd;
	assign unused_rd = rd_en;
endmodule : rftmr_timer
`default_nettype wire

// ===== sim/rftmr_timer_sva.sv
// Checker for the reader timer: APB answers, run control, timer-two copy.
// Assumes it is bound to rftmr_timer and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rftmr_timer_sva #(
	parameter int COUNT_W = 16
) (
	// Clock and reset
	input wire logic CLK,
	input wire logic RST_N,
	// APB
	input wire logic [31:0] PADDR,
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [31:0] PWDATA,
	input wire logic [31:0] PRDATA,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Timer outputs
	input wire logic UNDERFLOW,
	input wire logic RUNNING,
	input wire logic [7:0] TIMER_TWO_CONTROL,
	input wire logic IRQ
);
	default clocking @(posedge CLK); endclocking
	default disable iff (!RST_N);
	logic acc;
	logic ok;
	logic t2w;
	logic [7:0] ix;
	assign acc = PSEL && PENABLE;
	assign ix = PADDR[9:2];
	assign ok = PADDR[31:10] == 22'h0 && PADDR[1:0] == 2'b00
		&& (ix inside {[8'h14:8'h19], [8'h20:8'h22]});
	assign t2w = acc && PWRITE && ok && ix == 8'h19;
	sequence s_run_wr(logic [1:0] b);
		acc && PWRITE && ok && ix == 8'h20 && PWDATA[1:0] == b;
	endsequence
	sequence s_t2_wr;
		t2w;
	endsequence
	a_unmapped_error: assert property (acc && !ok |-> PSLVERR)
		else $error("unmapped access without error");
	a_mapped_no_error: assert property (acc && ok |-> !PSLVERR)
		else $error("mapped access flagged as error");
	a_reserved_read_zero: assert property (acc && !PWRITE && ok && (ix == 8'h14 || ix == 8'h19)
		|-> PRDATA[31:8] == 24'h0 && !PRDATA[6] && !PRDATA[2])
		else $error("reserved control bits read nonzero");
	a_count_byte_wide: assert property (acc && !PWRITE && ok && (ix == 8'h17 || ix == 8'h18)
		|-> PRDATA[31:8] == 24'h0)
		else $error("count byte wider than eight bits");
	a_t2_copy_write: assert property (s_t2_wr |=> {24'h0, TIMER_TWO_CONTROL}
		== ($past(PWDATA) & 32'h0000_00BB))
		else $error("timer two control copy wrong");
	a_t2_copy_hold: assert property (!t2w |=> $stable(TIMER_TWO_CONTROL))
		else $error("timer two control changed without write");
	a_run_start_write: assert property (s_run_wr(2'b11) |=> RUNNING)
		else $error("run write did not start timer");
	a_run_stop_write: assert property (s_run_wr(2'b10) |=> !RUNNING)
		else $error("run write did not stop timer");
	a_reset_idle: assert property ($rose(RST_N)
		|-> !RUNNING && !IRQ && !UNDERFLOW && TIMER_TWO_CONTROL == 8'h00)
		else $error("outputs not idle after reset");
	a_uf_while_run: assert property (UNDERFLOW |-> $past(RUNNING) || $past(RUNNING, 2))
		else $error("underflow while stopped");
endmodule : rftmr_timer_sva
bind rftmr_timer rftmr_timer_sva #(.COUNT_W(COUNT_W)) u_sva (.CLK(CLK), .RST_N(RST_N),
	.PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PWDATA(PWDATA),
	.PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .UNDERFLOW(UNDERFLOW),
	.RUNNING(RUNNING), .TIMER_TWO_CONTROL(TIMER_TWO_CONTROL), .IRQ(IRQ));
`default_nettype wire

// ===== sim/rftmr_timer_bench.sv
// Self-checking bench for the reader timer: APB tasks and event pulses.
// Assumes the package, design and checker are compiled before it.
`timescale 1ns/1ps
`default_nettype none
module rftmr_timer_bench;
	logic CLK = 1'b0;
	logic RST_N = 1'b0;
	logic [31:0] PADDR = 32'h0;
	logic PSEL = 1'b0;
	logic PENABLE = 1'b0;
	logic PWRITE = 1'b0;
	logic [31:0] PWDATA = 32'h0;
	logic RX_ACTIVE = 1'b0;
	// Tx done, rx bit, oscillator, fast tick, timer0 and timer2 underflow
	logic [5:0] ev = 6'h0;
	logic [31:0] PRDATA;
	logic PREADY;
	logic PSLVERR;
	logic UNDERFLOW;
	logic RUNNING;
	logic IRQ;
	logic [7:0] TIMER_TWO_CONTROL;
	logic [31:0] rv;
	logic [31:0] r1;
	logic re;
	logic [7:0] ix [9] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h18, 8'h19, 8'h20, 8'h21, 8'h22};
	int err_total = 0;
	int samples_checked = 0;
	int uf_cnt = 0;
	rftmr_timer DUT (.CLK(CLK), .RST_N(RST_N), .PADDR(PADDR), .PSEL(PSEL), .PENABLE(PENABLE),
		.PWRITE(PWRITE), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
		.TX_DONE(ev[0]), .RX_BIT_VALID(ev[1]), .RX_ACTIVE(RX_ACTIVE), .LFO_IN(ev[2]),
		.FAST_TICK(ev[3]), .TIMER0_UNDERFLOW(ev[4]), .TIMER2_UNDERFLOW(ev[5]),
		.UNDERFLOW(UNDERFLOW), .RUNNING(RUNNING), .TIMER_TWO_CONTROL(TIMER_TWO_CONTROL), .IRQ(IRQ));
	initial begin
		forever #25 CLK = ~CLK;
	end
	// Underflow pulses counted on the falling edge, where the pulse is settled
	always @(negedge CLK) begin
		if (UNDERFLOW === 1'b1)
			uf_cnt <= uf_cnt + 1;
	end
	// ----
	// Tasks
	// ----
	task automatic chk(input logic [31:0] s, input logic [31:0] e);
		samples_checked++;
		if (s !== e) begin
			err_total++;
			$display("unexpected at %0t: seen %h expected %h", $time, s, e);
		end
	endtask : chk
	// PRDATA and PSLVERR are taken at the access edge, other outputs on the falling edge after it
	task automatic bus(input logic w, input logic [7:0] i, input logic [31:0] d);
		@(posedge CLK);
		PSEL <= 1'b1;
		PWRITE <= w;
		PADDR <= {22'h0, i, 2'b00};
		PWDATA <= d;
		@(posedge CLK);
		PENABLE <= 1'b1;
		@(posedge CLK);
		while (PREADY !== 1'b1)
			@(posedge CLK);
		rv = PRDATA;
		re = PSLVERR;
		PSEL <= 1'b0;
		PENABLE <= 1'b0;
		@(negedge CLK);
	endtask : bus
	task automatic pl(input int b, input int n);
		repeat (n) begin
			@(posedge CLK);
			ev[b] <= 1'b1;
			@(posedge CLK);
			ev[b] <= 1'b0;
		end
		repeat (2) @(posedge CLK);
		@(negedge CLK);
	endtask : pl
	// read only outside reception; bytes may tear
	task automatic cnt(input logic [15:0] e);
		bus(1'b0, 8'h17, 32'h0);
		chk(rv, {24'h0, e[15:8]});
		bus(1'b0, 8'h18, 32'h0);
		chk(rv, {24'h0, e[7:0]});
	endtask : cnt
	task automatic go(input logic [7:0] c, input logic [15:0] r);
		bus(1'b1, 8'h14, {24'h0, c});
		bus(1'b1, 8'h15, {24'h0, r[15:8]});
		bus(1'b1, 8'h16, {24'h0, r[7:0]});
		bus(1'b1, 8'h20, 32'h3);
	endtask : go
	task automatic run(input logic e);
		chk(32'(RUNNING), 32'(e));
	endtask : run
	task automatic print_verdict;
		if (err_total == 0 && samples_checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (20000) @(posedge CLK);
		err_total++;
		print_verdict();
	end
	// ----
	// Tests
	// ----
	initial begin
		repeat (6) @(posedge CLK);
		RST_N <= 1'b1;
		foreach (ix[k]) begin
			bus(1'b0, ix[k], 32'h0);
			chk(rv, 32'h0);
		end
		bus(1'b1, 8'h14, 32'hFF);
		bus(1'b0, 8'h14, 32'h0);
		chk(rv, 32'hBB);
		bus(1'b1, 8'h19, 32'hFF);
		chk({24'h0, TIMER_TWO_CONTROL}, 32'hBB);
		bus(1'b1, 8'h19, 32'h0);
		bus(1'b0, 8'h30, 32'h0);
		chk({rv[31:1], re}, 32'h1);
		bus(1'b1, 8'h17, 32'hFF);
		cnt(16'h0000);
		go(8'h02, 16'h0105);
		cnt(16'h0105);
		pl(4, 3);
		cnt(16'h0102);
		pl(5, 2);
		cnt(16'h0102);
		bus(1'b1, 8'h15, 32'h22);
		cnt(16'h0102);
		bus(1'b1, 8'h16, 32'h33);
		cnt(16'h0102);
		bus(1'b1, 8'h20, 32'h2);
		bus(1'b1, 8'h20, 32'h3);
		cnt(16'h2233);
		bus(1'b1, 8'h20, 32'h2);
		bus(1'b1, 8'h20, 32'h1);
		run(1'b0);
		go(8'h03, 16'h0002);
		pl(5, 2);
		cnt(16'h0000);
		run(1'b0);
		chk(32'(uf_cnt), 32'h1);
		bus(1'b0, 8'h21, 32'h0);
		chk(rv, 32'h1);
		chk(32'(IRQ), 32'h0);
		bus(1'b1, 8'h22, 32'h1);
		chk(32'(IRQ), 32'h1);
		bus(1'b1, 8'h21, 32'h1);
		chk(32'(IRQ), 32'h0);
		go(8'h0B, 16'h0002);
		pl(5, 3);
		cnt(16'h0001);
		run(1'b1);
		chk(32'(uf_cnt), 32'h2);
		bus(1'b1, 8'h20, 32'h2);
		bus(1'b1, 8'h21, 32'h1);
		bus(1'b1, 8'h14, 32'h02);
		pl(0, 1);
		run(1'b0);
		bus(1'b1, 8'h14, 32'h12);
		bus(1'b1, 8'h15, 32'h0);
		bus(1'b1, 8'h16, 32'h7);
		pl(0, 1);
		run(1'b1);
		cnt(16'h0007);
		@(posedge CLK) RX_ACTIVE <= 1'b1;
		pl(1, 5);
		run(1'b1);
		@(posedge CLK) RX_ACTIVE <= 1'b0;
		bus(1'b1, 8'h14, 32'h92);
		pl(0, 1);
		@(posedge CLK) RX_ACTIVE <= 1'b1;
		pl(1, 3);
		run(1'b1);
		pl(1, 1);
		run(1'b0);
		@(posedge CLK) RX_ACTIVE <= 1'b0;
		bus(1'b1, 8'h16, 32'h1);
		bus(1'b1, 8'h14, 32'hB2);
		pl(2, 1);
		run(1'b1);
		@(posedge CLK) RX_ACTIVE <= 1'b1;
		pl(1, 4);
		run(1'b1);
		@(posedge CLK) RX_ACTIVE <= 1'b0;
		pl(4, 1);
		bus(1'b0, 8'h21, 32'h0);
		chk(rv, 32'h1);
		chk(32'(uf_cnt), 32'h3);
		bus(1'b1, 8'h21, 32'h1);
		bus(1'b1, 8'h14, 32'h22);
		pl(2, 1);
		pl(4, 2);
		cnt(16'h0001);
		bus(1'b0, 8'h21, 32'h0);
		chk(rv, 32'h0);
		chk(32'(uf_cnt), 32'h3);
		pl(2, 1);
		run(1'b0);
		go(8'h00, 16'h0010);
		pl(3, 4);
		cnt(16'h000C);
		go(8'h01, 16'h0080);
		bus(1'b0, 8'h18, 32'h0);
		r1 = rv;
		repeat (rftmr_pkg::SLOW_DIV_CYCLES - 3) @(posedge CLK);
		bus(1'b0, 8'h18, 32'h0);
		chk(rv, r1 - 32'h1);
		print_verdict();
	end
endmodule : rftmr_timer_bench
`default_nettype wire
